// ---- core/rtcmya_cfg.svh ----
`ifndef RTCMYA_CFG_SVH
`define RTCMYA_CFG_SVH
`define RTCMYA_OFF_MONTH     12'h000
`define RTCMYA_OFF_YEAR      12'h004
`define RTCMYA_OFF_CORR      12'h008
`define RTCMYA_OFF_ALM_MIN   12'h00C
`define RTCMYA_OFF_ALM_HOUR  12'h010
`define RTCMYA_OFF_ALM_WDAY  12'h014
`define RTCMYA_OFF_STATUS    12'h018
`define RTCMYA_RST_MONTH     8'h01
`define RTCMYA_RST_YEAR      8'h00
`define RTCMYA_RST_CORR      8'h00
`define RTCMYA_RST_ALM       8'h00
`define RTCMYA_SUB_NOMINAL   16'h7FFF
`define RTCMYA_CORR_SEL_BIT  7
`define RTCMYA_CORR_SIGN_BIT 6
`define RTCMYA_PM_BIT        5
`define RTCMYA_XFER_MAX_TICKS 2
`endif

// ---- core/rtcmya_pkg.sv ----
package rtcmya_pkg;
    typedef logic [7:0] rtcmya_bcd_t;
    typedef enum logic [2:0]
    {
        RTCMYA_XF_IDLE = 3'b001,
        RTCMYA_XF_WAIT = 3'b010,
        RTCMYA_XF_LOAD = 3'b100
    } rtcmya_xfer_t;
endpackage : rtcmya_pkg

// ---- core/rtcmya_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtcmya_cfg.svh"
// Contract
// - Month counts BCD 01..12 on day overflow
// - Month and year writes buffered, loaded within two ticks
// - Year counts BCD 00..99 on month overflow
// - Year multiple of four is leap
// - Correction shifts sub-second carry point
// - Select 0 corrects at 00,20,40 s
// - Select 1 corrects at 00 s only
// - Positive: add (magnitude minus one) times two
// - Negative: subtract (inverse plus one) times two
// - Bits five..one zero means no correction
// - Backup mode suspends correction
// - Correction clears only at power-on reset
// - Alarm minute outside 00..59 never matches
// - Alarm hour out of range never matches
// - Alarm hour bit five marks p.m.
// - Format bit: 0 twelve-hour, 1 twenty-four
// - Day overflow depends on month and leap
module rtcmya_top
    import rtcmya_pkg::*;
(
    input  wire logic               pclk,              // APB clock, 100 MHz
    input  wire logic               presetn,           // Power-on reset of RTC supply, low
    input  wire logic               psel,              // APB select
    input  wire logic               penable,           // APB enable
    input  wire logic               pwrite,            // APB direction
    input  wire logic [11:0]        paddr,             // APB byte address
    input  wire logic [31:0]        pwdata,            // APB write data
    output logic                    pready,            // APB ready
    output logic [31:0]             prdata,            // APB read data
    output logic                    pslverr,           // APB error
    input  wire logic               count_tick,        // 32.768 kHz enable pulse
    input  wire logic               day_overflow,      // Day counter wraps, pulse
    input  wire logic               hour_format_select,// 0 twelve, 1 twenty-four hour
    input  wire logic               backup_mode,       // RTC in backup mode
    input  wire rtcmya_pkg::rtcmya_bcd_t seconds_counter, // Current seconds
    input  wire rtcmya_pkg::rtcmya_bcd_t minute_counter,  // Current minutes
    input  wire rtcmya_pkg::rtcmya_bcd_t hour_counter,    // Current hours
    input  wire rtcmya_pkg::rtcmya_bcd_t weekday_counter, // Current weekday 0..6
    output logic [15:0]             subsecond_limit,   // Sub-count carry point
    output logic                    month_overflow,    // Month wraps, pulse
    output logic [5:0]              days_in_month,     // Day overflow point, BCD
    output logic                    leap_year,         // Leap year flag
    output logic                    alarm_interrupt    // Alarm match, pulse
);
    import rtcmya_pkg::*;

    rtcmya_bcd_t  month_ff, year_ff, corr_ff, alm_min_ff, alm_hour_ff, alm_wday_ff;
    rtcmya_bcd_t  buf_month_ff, buf_year_ff;
    logic         pend_month_ff, pend_year_ff;
    rtcmya_xfer_t xfer_ff;
    logic [7:0]   prev_min_ff;
    logic         alarm_ff, ovf_ff;
    logic [31:0]  rdata_ff;

    function automatic rtcmya_bcd_t bcd_inc(input rtcmya_bcd_t v);
        if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic bcd_in(input rtcmya_bcd_t v, input rtcmya_bcd_t lo,
                                    input rtcmya_bcd_t hi);
        bcd_in = (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction : bcd_in

    // APB: zero wait state, every access completes at its first access cycle
    wire wr_en = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign prdata  = rdata_ff;
    assign pslverr = 1'b0;

    wire hit_month = (paddr == `RTCMYA_OFF_MONTH);
    wire hit_year  = (paddr == `RTCMYA_OFF_YEAR);

    // Buffered counter writes, taken over on a later tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_month_ff <= `RTCMYA_RST_MONTH;
            buf_year_ff  <= `RTCMYA_RST_YEAR;
        end
        else if (wr_en)
        begin
            if (hit_month)
                buf_month_ff <= pwdata[7:0];
            if (hit_year)
                buf_year_ff <= pwdata[7:0];
        end
    end

    // Pending sets win over the clear done by the load
    wire load = (xfer_ff == RTCMYA_XF_LOAD);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_month_ff <= 1'b0;
            pend_year_ff  <= 1'b0;
        end
        else
        begin
            pend_month_ff <= (wr_en && hit_month) || (pend_month_ff && !load);
            pend_year_ff  <= (wr_en && hit_year) || (pend_year_ff && !load);
        end
    end

    // Wait for the next tick, load in the cycle after it: at most two ticks after the write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xfer_ff <= RTCMYA_XF_IDLE;
        else
        begin
            case (xfer_ff)
                RTCMYA_XF_IDLE:
                    if (pend_month_ff || pend_year_ff)
                        xfer_ff <= RTCMYA_XF_WAIT;
                RTCMYA_XF_WAIT:
                    if (count_tick)
                        xfer_ff <= RTCMYA_XF_LOAD;
                RTCMYA_XF_LOAD:
                    xfer_ff <= RTCMYA_XF_IDLE;
                default:
                    xfer_ff <= RTCMYA_XF_IDLE;
            endcase
        end
    end

    wire month_wrap = (month_ff == 8'h12);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            month_ff <= `RTCMYA_RST_MONTH;
        else if (load && pend_month_ff)
            month_ff <= buf_month_ff;
        else if (day_overflow)
            month_ff <= month_wrap ? 8'h01 : bcd_inc(month_ff);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_ff <= 1'b0;
        else
            ovf_ff <= day_overflow && month_wrap && !(load && pend_month_ff);
    end
    assign month_overflow = ovf_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            year_ff <= `RTCMYA_RST_YEAR;
        else if (load && pend_year_ff)
            year_ff <= buf_year_ff;
        else if (ovf_ff)
            year_ff <= (year_ff == 8'h99) ? 8'h00 : bcd_inc(year_ff);
    end

    // BCD value is a multiple of four when tens parity matches units mod 4
    assign leap_year = year_ff[4] ? (year_ff[1:0] == 2'b10 && !year_ff[3])
                                  : (year_ff[1:0] == 2'b00 && year_ff[3:2] != 2'b11)
                                    || (year_ff[3:0] == 4'h8);

    always_comb
    begin
        case (month_ff)
            8'h02:   days_in_month = leap_year ? 6'h29 : 6'h28;
            8'h04, 8'h06, 8'h09, 8'h11:
                     days_in_month = 6'h30;
            default: days_in_month = 6'h31;
        endcase
    end

    // Correction register: only presetn clears it; software keeps rewrite timing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            corr_ff <= `RTCMYA_RST_CORR;
        else if (wr_en && paddr == `RTCMYA_OFF_CORR)
            corr_ff <= pwdata[7:0];
    end

    wire corr_second = corr_ff[`RTCMYA_CORR_SEL_BIT]
                     ? (seconds_counter == 8'h00)
                     : (seconds_counter == 8'h00 || seconds_counter == 8'h20
                        || seconds_counter == 8'h40);
    wire corr_active = corr_second && (corr_ff[5:1] != 5'h00) && !backup_mode;
    wire [15:0] inc_val = {9'h000, (corr_ff[5:0] - 6'h01), 1'b0};
    wire [15:0] dec_val = {9'h000, (~corr_ff[5:0] + 6'h01), 1'b0};

    always_comb
    begin
        if (!corr_active)
            subsecond_limit = `RTCMYA_SUB_NOMINAL;
        else if (corr_ff[`RTCMYA_CORR_SIGN_BIT])
            subsecond_limit = `RTCMYA_SUB_NOMINAL - dec_val;
        else
            subsecond_limit = `RTCMYA_SUB_NOMINAL + inc_val;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alm_min_ff  <= `RTCMYA_RST_ALM;
            alm_hour_ff <= `RTCMYA_RST_ALM;
            alm_wday_ff <= `RTCMYA_RST_ALM;
        end
        else if (wr_en)
        begin
            if (paddr == `RTCMYA_OFF_ALM_MIN)
                alm_min_ff <= pwdata[7:0];
            else if (paddr == `RTCMYA_OFF_ALM_HOUR)
                alm_hour_ff <= pwdata[7:0];
            else if (paddr == `RTCMYA_OFF_ALM_WDAY)
                alm_wday_ff <= {1'b0, pwdata[6:0]};
        end
    end

    wire min_ok  = bcd_in(alm_min_ff, 8'h00, 8'h59);
    wire hour_ok = hour_format_select ? bcd_in(alm_hour_ff, 8'h00, 8'h23)
                 : (bcd_in(alm_hour_ff, 8'h01, 8'h12)
                    || bcd_in(alm_hour_ff, 8'h21, 8'h32));
    wire day_ok  = (weekday_counter <= 8'h06) && alm_wday_ff[weekday_counter[2:0]];
    wire match   = min_ok && hour_ok && day_ok && (minute_counter == alm_min_ff)
                 && (hour_counter == alm_hour_ff);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_min_ff <= 8'h00;
            alarm_ff    <= 1'b0;
        end
        else
        begin
            prev_min_ff <= minute_counter;
            alarm_ff    <= match && (minute_counter != prev_min_ff);
        end
    end
    assign alarm_interrupt = alarm_ff;

    // Status word gives leap flag and pending transfer state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_ff <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == `RTCMYA_OFF_MONTH)
                rdata_ff <= {24'h000000, month_ff};
            else if (paddr == `RTCMYA_OFF_YEAR)
                rdata_ff <= {24'h000000, year_ff};
            else if (paddr == `RTCMYA_OFF_CORR)
                rdata_ff <= {24'h000000, corr_ff};
            else if (paddr == `RTCMYA_OFF_ALM_MIN)
                rdata_ff <= {24'h000000, alm_min_ff};
            else if (paddr == `RTCMYA_OFF_ALM_HOUR)
                rdata_ff <= {24'h000000, alm_hour_ff};
            else if (paddr == `RTCMYA_OFF_ALM_WDAY)
                rdata_ff <= {24'h000000, alm_wday_ff};
            else if (paddr == `RTCMYA_OFF_STATUS)
                rdata_ff <= {29'h0, leap_year, pend_year_ff, pend_month_ff};
            else
                rdata_ff <= 32'h0000_0000;
        end
    end

endmodule : rtcmya_top
`default_nettype wire

// ---- verif/rtcmya_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtcmya_chk
    import rtcmya_pkg::*;
(
    input wire logic                   pclk,               // Clock
    input wire logic                   presetn,            // Reset
    input wire logic                   day_overflow,       // Day wrap
    input wire logic                   hour_format_select, // Hour mode
    input wire logic                   backup_mode,        // Backup
    input wire rtcmya_pkg::rtcmya_bcd_t seconds_counter,   // Seconds
    input wire rtcmya_pkg::rtcmya_bcd_t minute_counter,    // Minutes
    input wire rtcmya_pkg::rtcmya_bcd_t hour_counter,      // Hours
    input wire logic [15:0]            subsecond_limit,    // Carry point
    input wire logic                   month_overflow,     // Month wrap
    input wire logic                   alarm_interrupt     // Alarm
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_sub_backup: assert property (backup_mode |-> subsecond_limit == 16'h7FFF)
        else $error("limit moved in backup mode");
    chk_sub_offsec: assert property (!(seconds_counter inside {8'h00, 8'h20, 8'h40})
        |-> subsecond_limit == 16'h7FFF) else $error("limit moved off a correction second");
    chk_corr_even: assert property (subsecond_limit[0] == 1'b1)
        else $error("odd correction step");
    chk_month_cause: assert property (month_overflow
        |-> $past(day_overflow) && !$past(month_overflow)) else $error("month wrap uncaused");
    chk_alarm_change: assert property (alarm_interrupt
        |-> $past(minute_counter) != $past(minute_counter, 2)) else $error("alarm without tick");
    chk_alarm_once: assert property (alarm_interrupt |=> !alarm_interrupt [*2])
        else $error("alarm repeated");
    chk_alarm_minok: assert property (alarm_interrupt |-> $past(minute_counter) <= 8'h59
        && $past(minute_counter[3:0]) <= 4'h9) else $error("alarm on bad minute");
    chk_alarm_hour24: assert property (alarm_interrupt && $past(hour_format_select)
        |-> $past(hour_counter) <= 8'h23) else $error("alarm on bad hour");
    cover property (alarm_interrupt);
    cover property (month_overflow);
    cover property (subsecond_limit != 16'h7FFF);
endmodule : rtcmya_chk
bind rtcmya_top rtcmya_chk u_chk (.pclk(pclk), .presetn(presetn), .day_overflow(day_overflow),
    .hour_format_select(hour_format_select), .backup_mode(backup_mode),
    .seconds_counter(seconds_counter), .minute_counter(minute_counter),
    .hour_counter(hour_counter), .subsecond_limit(subsecond_limit),
    .month_overflow(month_overflow), .alarm_interrupt(alarm_interrupt));
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtcmya_cfg.svh"
module tb_top;
    import rtcmya_pkg::*;
    localparam int TICK = 3052;
    localparam int LOAD = 2 * TICK + 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        count_tick, day_overflow, hour_format_select, backup_mode;
    logic        month_overflow, leap_year, alarm_interrupt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] subsecond_limit;
    logic [5:0]  days_in_month;
    rtcmya_bcd_t seconds_counter, minute_counter, hour_counter, weekday_counter;
    int          n_errors, total_checks, pulses, cyc, base;
    logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h020};
    logic [31:0] rw [7] = '{32'hFFFFFF12, 32'h99, 32'hC5, 32'h59, 32'h32, 32'hFF, 32'hFF};
    logic [31:0] re [7] = '{32'h12, 32'h99, 32'hC5, 32'h59, 32'h32, 32'h7F, 32'h0};
    logic [39:0] ct [9] = '{40'h05_20_00_8007, 40'h05_21_00_7FFF, 40'h05_40_01_7FFF,
        40'h85_20_00_7FFF, 40'h85_00_00_8007, 40'h7B_40_00_7FF5, 40'h7F_00_00_7FFD,
        40'h41_00_00_7FFF, 40'h01_20_00_7FFF};
    logic [51:0] at [8] = '{52'h0_1_25_30_25_01_30, 52'h0_0_25_30_25_00_30,
        52'h0_0_25_30_05_01_30, 52'h0_0_25_30_25_05_31, 52'h0_1_12_00_12_05_00,
        52'h1_1_17_30_17_02_30, 52'h1_0_17_5A_17_02_5A, 52'h1_0_24_30_24_02_30};
    logic [7:0]  yr [4] = '{8'h96, 8'h99, 8'h10, 8'h12};
    logic        ly [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    rtcmya_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .count_tick(count_tick), .day_overflow(day_overflow),
        .hour_format_select(hour_format_select), .backup_mode(backup_mode),
        .seconds_counter(seconds_counter), .minute_counter(minute_counter),
        .hour_counter(hour_counter), .weekday_counter(weekday_counter),
        .subsecond_limit(subsecond_limit), .month_overflow(month_overflow),
        .days_in_month(days_in_month), .leap_year(leap_year), .alarm_interrupt(alarm_interrupt));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // The tick runs free so buffered loads see a real count-clock cadence
    always @(posedge pclk)
    begin
        cyc <= (cyc == TICK - 1) ? 0 : cyc + 1;
        count_tick <= (cyc == TICK - 1);
        if (alarm_interrupt === 1'b1) pulses <= pulses + 1;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(posedge pclk);
    endtask : waitc
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t no ready on bus", $time);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-raises psel in the same step
        @(posedge pclk);
    endtask : apb
    task automatic test_done();
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        #800000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, day_overflow, backup_mode} = '0;
        {hour_format_select, seconds_counter, minute_counter, hour_counter} = '0;
        weekday_counter = '0;
        presetn = 1'b0;
        waitc(6);
        presetn <= 1'b1;
        waitc(1);
        apb(0, `RTCMYA_OFF_CORR, 0);
        chk(rd, 0);
        chk(leap_year, 1);
        for (int i = 0; i < 7; i++)
        begin
            apb(1, ra[i], rw[i]);
            if (ra[i] < 12'h008)
                waitc(LOAD);
            apb(0, ra[i], 0);
            chk(rd, re[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `RTCMYA_OFF_YEAR, {24'h0, yr[i]});
            waitc(LOAD);
            chk(leap_year, ly[i]);
        end
        apb(1, `RTCMYA_OFF_MONTH, 32'h02);
        apb(0, `RTCMYA_OFF_STATUS, 0);
        chk(rd, 32'h5);
        waitc(LOAD);
        chk(days_in_month, 6'h29);
        apb(1, `RTCMYA_OFF_MONTH, 32'h11);
        waitc(LOAD);
        chk(days_in_month, 6'h30);
        apb(1, `RTCMYA_OFF_MONTH, 32'h12);
        apb(1, `RTCMYA_OFF_YEAR, 32'h99);
        waitc(LOAD);
        chk(days_in_month, 6'h31);
        for (int i = 0; i < 2; i++)
        begin
            day_overflow <= 1'b1;
            waitc(1);
            day_overflow <= 1'b0;
            #1 chk(month_overflow, i == 0);
            waitc(3);
            apb(0, `RTCMYA_OFF_MONTH, 0);
            chk(rd, i + 1);
        end
        apb(0, `RTCMYA_OFF_YEAR, 0);
        chk(rd, 0);
        apb(1, `RTCMYA_OFF_YEAR, 32'h01);
        waitc(LOAD);
        chk(days_in_month, 6'h28);
        for (int i = 0; i < 9; i++)
        begin
            apb(1, `RTCMYA_OFF_CORR, {24'h0, ct[i][39:32]});
            seconds_counter <= ct[i][31:24];
            backup_mode <= ct[i][16];
            waitc(2);
            chk(subsecond_limit, ct[i][15:0]);
        end
        presetn <= 1'b0;
        waitc(2);
        presetn <= 1'b1;
        waitc(1);
        apb(0, `RTCMYA_OFF_CORR, 0);
        chk(rd, 0);
        apb(1, `RTCMYA_OFF_ALM_WDAY, 32'h26);
        for (int i = 0; i < 8; i++)
        begin
            hour_format_select <= at[i][44];
            apb(1, `RTCMYA_OFF_ALM_HOUR, {24'h0, at[i][39:32]});
            apb(1, `RTCMYA_OFF_ALM_MIN, {24'h0, at[i][31:24]});
            hour_counter <= at[i][23:16];
            weekday_counter <= at[i][15:8];
            minute_counter <= 8'h29;
            waitc(3);
            base = pulses;
            minute_counter <= at[i][7:0];
            waitc(6);
            chk(pulses - base, at[i][43:40]);
        end
        test_done();
    end
endmodule : tb_top
`default_nettype wire
